// [include/fpc_pkg.sv]
// Constants, register map and state types of the four-lane media control block
package fpc_pkg;

    // ****************************************************************
    // Sizes and timing
    // ****************************************************************
    localparam int          LANES         = 4;
    localparam int          CLK_MHZ       = 25;
    localparam int          LOSS_MIN_US   = 250;
    localparam int          LOSS_MAX_US   = 500;
    localparam int          LOSS_MIN_CYC  = LOSS_MIN_US * CLK_MHZ;
    localparam int          LOSS_MAX_CYC  = LOSS_MAX_US * CLK_MHZ;
    localparam int          LOSS_CNT_W    = 15;
    localparam int          MAX_DELAY_BT  = 512;
    localparam int          PATH_CYCLES   = 1;
    localparam logic        TX_OFF_LEVEL  = 1'b0;

    // ****************************************************************
    // Register map (byte addresses, 32-bit words)
    // ****************************************************************
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    localparam logic [7:0]  ADR_CTRL      = 8'h00;
    localparam logic [7:0]  ADR_LANE_OFF  = 8'h04;
    localparam logic [7:0]  ADR_STATUS    = 8'h08;
    localparam logic [7:0]  ADR_FAULTS    = 8'h0C;
    localparam logic [7:0]  ADR_IRQ_STAT  = 8'h10;
    localparam logic [7:0]  ADR_IRQ_MASK  = 8'h14;

    // CTRL fields
    localparam int          CTRL_ALL_OFF  = 0;
    localparam int          CTRL_LOOPBACK = 1;
    localparam int          CTRL_FLT_EN   = 2;
    localparam int          CTRL_FLT_ALL  = 3;
    // STATUS fields
    localparam int          ST_PRESENT_LO = 0;
    localparam int          ST_SIG_DET    = 4;
    localparam int          ST_ANY_FLT    = 5;
    localparam int          ST_TX_FLT     = 6;
    localparam int          ST_RX_FLT     = 7;
    // FAULTS fields
    localparam int          FL_TX_LO      = 0;
    localparam int          FL_RX_LO      = 4;
    // IRQ fields
    localparam int          IRQ_W         = 3;
    localparam int          IRQ_SD_LOST   = 0;
    localparam int          IRQ_SD_GAIN   = 1;
    localparam int          IRQ_FLT_RISE  = 2;

    localparam logic [3:0]  CTRL_RST      = 4'h0;
    localparam logic [3:0]  LANE_OFF_RST  = 4'h0;
    localparam logic [2:0]  IRQ_RST       = 3'h0;
    localparam logic [31:0] RD_ZERO       = 32'h0000_0000;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef logic [LOSS_CNT_W-1:0] fpc_cnt_t;

    typedef struct packed {
        logic [3:0] s1;
        logic [3:0] s2;
        logic [3:0] s3;
        logic [3:0] val;
    } fpc_sync_s;

    typedef struct packed {
        logic       all_off;
        logic       loopback;
        logic       flt_en;
        logic       flt_all;
        logic [3:0] lane_off;
    } fpc_ctrl_s;

    typedef struct packed {
        fpc_sync_s              lane;
        fpc_sync_s              sig_ok;
        fpc_sync_s              sig_low;
        fpc_sync_s              txf;
        fpc_sync_s              rxf;
        fpc_cnt_t [LANES-1:0]   loss_cnt;
        logic [3:0]             present;
        logic                   sig_det;
        logic                   any_flt;
        logic                   tx_flt;
        logic                   rx_flt;
        fpc_ctrl_s              ctrl;
        logic [IRQ_W-1:0]       irq_stat;
        logic [IRQ_W-1:0]       irq_mask;
        logic                   irq;
        logic [3:0]             out_lane;
        logic [3:0]             rx_bit;
        logic [DATA_W-1:0]      rdata;
    } fpc_state_s;

endpackage

// [rtl/fpc_pmd_ctrl.sv]
// Four-lane media control and status: lane mapping, signal detect, tx disable, loopback, faults
//
// Notes on behaviour
// - Four transmit bits drive four separate lanes
// - One is positive level, zero negative
// - Transmit bit n drives lane n
// - Four incoming lanes become four receive bits
// - Incoming lane n becomes receive bit n
// - Detect OK only when all lanes active
// - No FAIL before minimum loss window
// - FAIL after any lane loses past maximum
// - Global off forces all lanes constant
// - Per-lane off forces its own lane
// - Local fault forces all or faulted lane
// - Transmit-off controls never touch loopback
// - Loopback path provided, transmitters stay on
// - Per-lane signal present flag, same criteria
// - Any-fault flag set while any fault
// - Transmit-path fault flag follows tx faults
// - Receive-path fault flag follows rx faults
// - Total delay bounded by fixed limit
`timescale 1ns/10ps
`default_nettype none

module fpc_pmd_ctrl
    import fpc_pkg::*;
#(
    parameter int LOSS_CYCLES = LOSS_MIN_CYC + 1
) (
    input  wire logic              clock,
    input  wire logic              sys_rst,
    // Register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DATA_W-1:0] reg_rdata,
    output logic                   irq,
    // Upper sublayer side
    input  wire logic [3:0]        tx_bit,
    output logic      [3:0]        rx_bit,
    output logic                   signal_detect,
    output logic      [3:0]        lane_signal_present,
    output logic                   any_local_fault_flag,
    output logic                   tx_path_fault_flag,
    output logic                   rx_path_fault_flag,
    // Lane side
    output logic      [3:0]        out_lane,
    input  wire logic [3:0]        in_lane,
    input  wire logic [3:0]        lane_sig_ok,
    input  wire logic [3:0]        lane_sig_low,
    input  wire logic [3:0]        lane_tx_fault,
    input  wire logic [3:0]        lane_rx_fault
);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Three-stage pin synchroniser; value moves only when stages 2 and 3 agree
    function automatic fpc_sync_s sync_step(input fpc_sync_s cur, input logic [3:0] pin);
        fpc_sync_s nxt;
        nxt     = cur;
        nxt.s1  = pin;
        nxt.s2  = cur.s1;
        nxt.s3  = cur.s2;
        for (int i = 0; i < LANES; i++) begin
            if (cur.s2[i] == cur.s3[i]) begin
                nxt.val[i] = cur.s3[i];
            end
        end
        return nxt;
    endfunction

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] target);
        return a == target;
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************
    fpc_state_s state_q;
    fpc_state_s state_d;

    logic [3:0] tx_off;
    logic [3:0] tx_flt_now;
    logic [3:0] rx_flt_now;
    logic       any_flt_now;
    logic       sd_now;
    logic [3:0] present_now;
    logic [IRQ_W-1:0] irq_events;
    logic [IRQ_W-1:0] irq_w1c;
    logic [DATA_W-1:0] rd_val;

    always_comb begin
        state_d = state_q;

        // ************************************************************
        // Pin synchronisers
        // ************************************************************
        state_d.lane    = sync_step(state_q.lane, in_lane);
        state_d.sig_ok  = sync_step(state_q.sig_ok, lane_sig_ok);
        state_d.sig_low = sync_step(state_q.sig_low, lane_sig_low);
        state_d.txf     = sync_step(state_q.txf, lane_tx_fault);
        state_d.rxf     = sync_step(state_q.rxf, lane_rx_fault);

        // ************************************************************
        // Per-lane signal presence with loss windows
        // ************************************************************
        present_now = state_q.present;
        for (int i = 0; i < LANES; i++) begin
            if (state_q.sig_ok.val[i]) begin
                // Activity back: window restarts
                state_d.loss_cnt[i] = '0;
                present_now[i]      = 1'b1;
            end else if (state_q.sig_low.val[i]) begin
                if (state_q.loss_cnt[i] < LOSS_CNT_W'(LOSS_CYCLES)) begin
                    state_d.loss_cnt[i] = state_q.loss_cnt[i] + 1'b1;
                end else begin
                    // Only past the minimum window, well before the maximum
                    present_now[i] = 1'b0;
                end
            end else begin
                // Between thresholds is neither activity nor loss
                state_d.loss_cnt[i] = '0;
            end
        end
        state_d.present = present_now;
        sd_now          = &present_now;
        state_d.sig_det = sd_now;

        // ************************************************************
        // Fault flags
        // ************************************************************
        tx_flt_now     = state_q.txf.val;
        rx_flt_now     = state_q.rxf.val;
        state_d.tx_flt = |tx_flt_now;
        state_d.rx_flt = |rx_flt_now;
        any_flt_now    = (|tx_flt_now) | (|rx_flt_now);
        state_d.any_flt = any_flt_now;

        // ************************************************************
        // Transmit lanes
        // ************************************************************
        for (int i = 0; i < LANES; i++) begin
            tx_off[i] = state_q.ctrl.all_off
                      | state_q.ctrl.lane_off[i]
                      | (state_q.ctrl.flt_en
                         & (state_q.ctrl.flt_all ? any_flt_now
                                                 : (tx_flt_now[i] | rx_flt_now[i])));
            // Bit one maps to positive lane level, lane index kept
            state_d.out_lane[i] = tx_off[i] ? TX_OFF_LEVEL : tx_bit[i];
        end

        // ************************************************************
        // Receive path and loopback
        // ************************************************************
        // Loopback taps tx_bit ahead of the off gating; drivers keep running
        if (state_q.ctrl.loopback) begin
            state_d.rx_bit = tx_bit;
        end else begin
            state_d.rx_bit = state_q.lane.val;
        end

        // ************************************************************
        // Interrupt status
        // ************************************************************
        irq_events               = '0;
        irq_events[IRQ_SD_LOST]  = state_q.sig_det & ~sd_now;
        irq_events[IRQ_SD_GAIN]  = ~state_q.sig_det & sd_now;
        irq_events[IRQ_FLT_RISE] = ~state_q.any_flt & any_flt_now;
        irq_w1c = '0;
        if (reg_wr && hit(reg_addr, ADR_IRQ_STAT)) begin
            irq_w1c = reg_wdata[IRQ_W-1:0];
        end
        // New event wins over a clear in the same cycle
        state_d.irq_stat = (state_q.irq_stat & ~irq_w1c) | irq_events;

        // ************************************************************
        // Register writes
        // ************************************************************
        if (reg_wr) begin
            if (hit(reg_addr, ADR_CTRL)) begin
                state_d.ctrl.all_off  = reg_wdata[CTRL_ALL_OFF];
                state_d.ctrl.loopback = reg_wdata[CTRL_LOOPBACK];
                state_d.ctrl.flt_en   = reg_wdata[CTRL_FLT_EN];
                state_d.ctrl.flt_all  = reg_wdata[CTRL_FLT_ALL];
            end
            if (hit(reg_addr, ADR_LANE_OFF)) begin
                state_d.ctrl.lane_off = reg_wdata[LANES-1:0];
            end
            if (hit(reg_addr, ADR_IRQ_MASK)) begin
                state_d.irq_mask = reg_wdata[IRQ_W-1:0];
            end
        end
        state_d.irq = |(state_d.irq_stat & state_d.irq_mask);

        // ************************************************************
        // Register reads: data valid the cycle after the strobe only
        // ************************************************************
        rd_val = RD_ZERO;
        case (reg_addr)
            ADR_CTRL: begin
                rd_val[CTRL_ALL_OFF]  = state_q.ctrl.all_off;
                rd_val[CTRL_LOOPBACK] = state_q.ctrl.loopback;
                rd_val[CTRL_FLT_EN]   = state_q.ctrl.flt_en;
                rd_val[CTRL_FLT_ALL]  = state_q.ctrl.flt_all;
            end
            ADR_LANE_OFF: begin
                rd_val[LANES-1:0] = state_q.ctrl.lane_off;
            end
            ADR_STATUS: begin
                rd_val[ST_PRESENT_LO +: LANES] = state_q.present;
                rd_val[ST_SIG_DET]             = state_q.sig_det;
                rd_val[ST_ANY_FLT]             = state_q.any_flt;
                rd_val[ST_TX_FLT]              = state_q.tx_flt;
                rd_val[ST_RX_FLT]              = state_q.rx_flt;
            end
            ADR_FAULTS: begin
                rd_val[FL_TX_LO +: LANES] = state_q.txf.val;
                rd_val[FL_RX_LO +: LANES] = state_q.rxf.val;
            end
            ADR_IRQ_STAT: begin
                rd_val[IRQ_W-1:0] = state_q.irq_stat;
            end
            ADR_IRQ_MASK: begin
                rd_val[IRQ_W-1:0] = state_q.irq_mask;
            end
            default: begin
                rd_val = RD_ZERO;
            end
        endcase
        state_d.rdata = reg_rd ? rd_val : RD_ZERO;

        if (sys_rst) begin
            state_d = '0;
            state_d.ctrl.all_off  = CTRL_RST[CTRL_ALL_OFF];
            state_d.ctrl.loopback = CTRL_RST[CTRL_LOOPBACK];
            state_d.ctrl.flt_en   = CTRL_RST[CTRL_FLT_EN];
            state_d.ctrl.flt_all  = CTRL_RST[CTRL_FLT_ALL];
            state_d.ctrl.lane_off = LANE_OFF_RST;
            state_d.irq_stat      = IRQ_RST;
            state_d.irq_mask      = IRQ_RST;
        end
    end

    always_ff @(posedge clock) begin
        state_q <= state_d;
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign reg_rdata            = state_q.rdata;
    assign irq                  = state_q.irq;
    assign rx_bit               = state_q.rx_bit;
    assign signal_detect        = state_q.sig_det;
    assign lane_signal_present  = state_q.present;
    assign any_local_fault_flag = state_q.any_flt;
    assign tx_path_fault_flag   = state_q.tx_flt;
    assign rx_path_fault_flag   = state_q.rx_flt;
    assign out_lane             = state_q.out_lane;

endmodule

`default_nettype wire

// [verif/fpc_pmd_ctrl_props.sv]
// Concurrent checks on the ports of the four-lane media control block
`timescale 1ns/10ps
`default_nettype none

module fpc_pmd_ctrl_props
    import fpc_pkg::*;
#(
    parameter int LOSS_CYCLES = LOSS_MIN_CYC + 1
) (
    input wire logic              clock,
    input wire logic              sys_rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic              irq,
    input wire logic [3:0]        tx_bit,
    input wire logic [3:0]        rx_bit,
    input wire logic              signal_detect,
    input wire logic [3:0]        lane_signal_present,
    input wire logic              any_local_fault_flag,
    input wire logic              tx_path_fault_flag,
    input wire logic              rx_path_fault_flag,
    input wire logic [3:0]        out_lane,
    input wire logic [3:0]        lane_sig_ok,
    input wire logic [3:0]        lane_sig_low,
    input wire logic [3:0]        lane_tx_fault,
    input wire logic [3:0]        lane_rx_fault
);
    logic [3:0]       ctl_q;
    logic [3:0]       off_q;
    logic [IRQ_W-1:0] mask_q;
    logic [7:0]       run_q;

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    // Shadow of control writes, so lane gating can be predicted
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ctl_q <= CTRL_RST;
            off_q <= LANE_OFF_RST;
            mask_q <= IRQ_RST;
        end else if (reg_wr) begin
            if (reg_addr == ADR_CTRL) begin
                ctl_q <= reg_wdata[3:0];
            end
            if (reg_addr == ADR_LANE_OFF) begin
                off_q <= reg_wdata[3:0];
            end
            if (reg_addr == ADR_IRQ_MASK) begin
                mask_q <= reg_wdata[IRQ_W-1:0];
            end
        end
    end

    // Raw loss run on lane 0; saturates so a long outage never wraps
    always_ff @(posedge clock) begin
        if (sys_rst || lane_sig_ok[0] || !lane_sig_low[0]) begin
            run_q <= 8'h00;
        end else if (run_q != 8'hFF) begin
            run_q <= run_q + 8'h01;
        end
    end

    a_tx_lane_map: assert property (!ctl_q[CTRL_FLT_EN] |=>
        out_lane == ($past(tx_bit) & ~($past(off_q) | {4{$past(ctl_q[CTRL_ALL_OFF])}})))
        else $error("out_lane does not follow tx_bit");
    a_loop_path: assert property (ctl_q[CTRL_LOOPBACK] |=> rx_bit == $past(tx_bit))
        else $error("loopback rx_bit wrong");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == RD_ZERO)
        else $error("reg_rdata not zero outside read");
    a_irq_masked: assert property (irq |-> mask_q != IRQ_RST)
        else $error("irq high with all events masked");
    a_any_fault: assert property (any_local_fault_flag == (tx_path_fault_flag | rx_path_fault_flag))
        else $error("any fault flag wrong");
    a_tx_fault_set: assert property ((lane_tx_fault != 4'h0) [*8] |-> tx_path_fault_flag)
        else $error("tx fault flag missing");
    a_rx_fault_clr: assert property ((lane_rx_fault == 4'h0) [*8] |-> !rx_path_fault_flag)
        else $error("rx fault flag stuck");
    a_detect_all: assert property ((lane_signal_present != 4'hF) [*2] |-> !signal_detect)
        else $error("detect ok without all lanes");
    a_loss_late: assert property (int'(run_q) == LOSS_CYCLES + 10 |-> !lane_signal_present[0])
        else $error("lane 0 still present after long loss");
endmodule

bind fpc_pmd_ctrl fpc_pmd_ctrl_props #(.LOSS_CYCLES(LOSS_CYCLES)) u_props (
    .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .tx_bit(tx_bit),
    .rx_bit(rx_bit), .signal_detect(signal_detect), .lane_signal_present(lane_signal_present),
    .any_local_fault_flag(any_local_fault_flag), .tx_path_fault_flag(tx_path_fault_flag),
    .rx_path_fault_flag(rx_path_fault_flag), .out_lane(out_lane), .lane_sig_ok(lane_sig_ok),
    .lane_sig_low(lane_sig_low), .lane_tx_fault(lane_tx_fault), .lane_rx_fault(lane_rx_fault)
);

`default_nettype wire

// [verif/fpc_upper_model.sv]
// Model of the attachment logic above the lanes: streams bits down, latches bits up
`timescale 1ns/10ps
`default_nettype none

module fpc_upper_model
    import fpc_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       sys_rst,
    input  wire logic [3:0] send,
    input  wire logic [3:0] rx_bit,
    output logic      [3:0] tx_bit = 4'h0,
    output logic      [3:0] rx_seen = 4'h0
);
    // Same clock as the block, so bits change only just after an edge
    always @(posedge clock) begin
        if (sys_rst) begin
            tx_bit <= 4'h0;
            rx_seen <= 4'h0;
        end else begin
            tx_bit <= send;
            rx_seen <= rx_bit;
        end
    end
endmodule

`default_nettype wire

// [verif/tb_fpc_pmd_ctrl.sv]
// Directed bench of the four-lane media control block
`timescale 1ns/10ps
`default_nettype none

module tb_fpc_pmd_ctrl
    import fpc_pkg::*;
;
    localparam int LOSS = 20;
    logic        clock = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        irq, sd, any_f, tx_f, rx_f;
    logic [3:0]  tx_bit, rx_bit, pres, out_lane, rx_seen;
    logic [3:0]  send = 4'h0;
    logic [3:0]  in_lane = 4'h0;
    logic [3:0]  sig_ok = 4'h0;
    logic [3:0]  sig_low = 4'h0;
    logic [3:0]  tx_flt = 4'h0;
    logic [3:0]  rx_flt = 4'h0;
    logic [7:0]  zero_adr [5] = '{ADR_CTRL, ADR_LANE_OFF, ADR_IRQ_STAT, ADR_IRQ_MASK, 8'h20};
    int          n_mismatch = 0;
    int          check_count = 0;

    always #20 clock = ~clock;

    fpc_upper_model u_upper (
        .clock(clock), .sys_rst(sys_rst), .send(send), .rx_bit(rx_bit),
        .tx_bit(tx_bit), .rx_seen(rx_seen)
    );

    fpc_pmd_ctrl #(.LOSS_CYCLES(LOSS)) u_dut (
        .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .tx_bit(tx_bit),
        .rx_bit(rx_bit), .signal_detect(sd), .lane_signal_present(pres),
        .any_local_fault_flag(any_f), .tx_path_fault_flag(tx_f), .rx_path_fault_flag(rx_f),
        .out_lane(out_lane), .in_lane(in_lane), .lane_sig_ok(sig_ok), .lane_sig_low(sig_low),
        .lane_tx_fault(tx_flt), .lane_rx_fault(rx_flt)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    // Data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic summarize;
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (3000) @(posedge clock);
        n_mismatch++;
        summarize();
    end

    initial begin
        repeat (12) @(posedge clock);
        sys_rst <= 1'b0;
        foreach (zero_adr[i]) rd(zero_adr[i], 32'h0);
        wr(ADR_STATUS, 32'hFF);
        rd(ADR_STATUS, 32'h0);
        for (int i = 0; i < 4; i++) begin
            send <= 4'(1 << i);
            tick(3);
            chk(32'(out_lane), 32'h1 << i);
        end
        send <= 4'hF;
        for (int i = 0; i < 4; i++) begin
            wr(ADR_LANE_OFF, 32'h1 << i);
            tick(2);
            chk(32'(out_lane), 32'hF & ~(32'h1 << i));
        end
        wr(ADR_CTRL, 32'h3);
        wr(ADR_LANE_OFF, 32'hF);
        send <= 4'h6;
        tick(4);
        chk(32'(out_lane), 32'h0);
        chk(32'(rx_seen), 32'h6);
        wr(ADR_CTRL, 32'h2);
        wr(ADR_LANE_OFF, 32'h0);
        send <= 4'h9;
        tick(4);
        chk(32'({out_lane, rx_seen}), 32'h99);
        wr(ADR_CTRL, 32'h0);
        for (int i = 0; i < 4; i++) begin
            in_lane <= 4'(1 << i);
            tick(8);
            chk(32'(rx_bit), 32'h1 << i);
        end
        sig_ok <= 4'hF;
        tick(8);
        rd(ADR_STATUS, 32'h1F);
        tx_flt <= 4'h2;
        send <= 4'hF;
        tick(8);
        rd(ADR_STATUS, 32'h7F);
        rd(ADR_FAULTS, 32'h02);
        chk(32'({any_f, tx_f, rx_f}), 32'h6);
        wr(ADR_CTRL, 32'h4);
        tick(2);
        chk(32'(out_lane), 32'hD);
        wr(ADR_CTRL, 32'hC);
        tx_flt <= 4'h0;
        rx_flt <= 4'h8;
        tick(8);
        chk(32'(out_lane), 32'h0);
        rd(ADR_STATUS, 32'hBF);
        rd(ADR_FAULTS, 32'h80);
        chk(32'({any_f, tx_f, rx_f}), 32'h5);
        rx_flt <= 4'h0;
        wr(ADR_CTRL, 32'h0);
        tick(8);
        rd(ADR_STATUS, 32'h1F);
        rd(ADR_IRQ_STAT, 32'h6);
        chk(32'(irq), 32'h0);
        wr(ADR_IRQ_MASK, 32'h4);
        tick(1);
        chk(32'(irq), 32'h1);
        wr(ADR_IRQ_MASK, 32'h1);
        wr(ADR_IRQ_STAT, 32'h6);
        rd(ADR_IRQ_STAT, 32'h0);
        // Two short outages back to back: the run restarts between them
        repeat (2) begin
            sig_ok <= 4'hE;
            sig_low <= 4'h1;
            tick(12);
            sig_ok <= 4'hF;
            sig_low <= 4'h0;
            tick(4);
        end
        tick(4);
        chk(32'({irq, sd, pres}), 32'h1F);
        sig_ok <= 4'hE;
        sig_low <= 4'h1;
        tick(LOSS + 12);
        chk(32'({irq, sd, pres}), 32'h2E);
        rd(ADR_IRQ_STAT, 32'h1);
        wr(ADR_IRQ_STAT, 32'h1);
        tick(1);
        chk(32'(irq), 32'h0);
        summarize();
    end
endmodule

`default_nettype wire
